//--- rtpsd_pkg.sv
// Package for the submessage flag decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package rtpsd_pkg;
  // Submessage identifiers
  localparam logic [7:0] ID_HEARTBEAT = 8'h07;
  localparam logic [7:0] ID_GAP = 8'h08;
  localparam logic [7:0] ID_HB_FRAG = 8'h13;
  localparam logic [7:0] ID_DATA = 8'h15;
  localparam logic [7:0] ID_DATA_FRAG = 8'h16;
  // Flag positions
  localparam int unsigned F_ENDIAN = 0;
  localparam int unsigned F_QOS = 1;
  localparam int unsigned F_FINAL = 1;
  localparam int unsigned F_DATA = 2;
  localparam int unsigned F_LIVE = 2;
  localparam int unsigned F_FRAG_KEY = 2;
  localparam int unsigned F_KEY = 3;
  localparam int unsigned F_FRAG_NSTD = 3;
  localparam int unsigned F_NSTD = 4;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INVALID = 8'h08;
  localparam logic [7:0] OFS_DECODED = 8'h0C;
  // Control fields and reset value
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_CLR = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [2:0] {
    RTPSD_K_OTHER, RTPSD_K_DATA, RTPSD_K_FRAG, RTPSD_K_GAP, RTPSD_K_HB, RTPSD_K_HBFRAG
  } rtpsd_kind_e;

  typedef enum logic [1:0] {
    RTPSD_PL_NONE, RTPSD_PL_DATA, RTPSD_PL_KEY, RTPSD_PL_BAD
  } rtpsd_pl_e;
endpackage

//--- rtpsd_dec_if.sv
// Interface between the stream parser and the flag decoder.
// Assumes one parser and one decoder per instance.
`timescale 1ns/10ps
`default_nettype none
interface rtpsd_dec_if;
  logic [7:0] sub_id;
  logic [7:0] flags;
  rtpsd_pkg::rtpsd_kind_e kind;
  rtpsd_pkg::rtpsd_pl_e pl;
  logic little_end;
  logic inline_qos;
  logic nonstd;
  logic final_f;
  logic live;
  logic invalid;
  logic has_skip;
  modport dec (input sub_id, flags, output kind, pl, little_end, inline_qos, nonstd,
    final_f, live, invalid, has_skip);
  modport user (output sub_id, flags, input kind, pl, little_end, inline_qos, nonstd,
    final_f, live, invalid, has_skip);
endinterface
`default_nettype wire

//--- rtpsd_flag_dec.sv
// Combinational flag layout decoder, selected by submessage identifier.
// Assumes the parser registers whatever it keeps.
`timescale 1ns/10ps
`default_nettype none
module rtpsd_flag_dec (
  // Parser side
  rtpsd_dec_if.dec d
);
  always_comb begin
    d.kind = rtpsd_pkg::RTPSD_K_OTHER;
    d.pl = rtpsd_pkg::RTPSD_PL_NONE;
    d.little_end = d.flags[rtpsd_pkg::F_ENDIAN]; // R18
    d.inline_qos = 1'b0;
    d.nonstd = 1'b0;
    d.final_f = 1'b0;
    d.live = 1'b0;
    d.invalid = 1'b0;
    d.has_skip = 1'b0;
    // Unused bits are never looked at
    case (d.sub_id) // R19
      rtpsd_pkg::ID_DATA: begin // R20
        d.kind = rtpsd_pkg::RTPSD_K_DATA;
        d.has_skip = 1'b1;
        d.inline_qos = d.flags[rtpsd_pkg::F_QOS]; // R1
        d.nonstd = d.flags[rtpsd_pkg::F_NSTD]; // R7
        case ({d.flags[rtpsd_pkg::F_KEY], d.flags[rtpsd_pkg::F_DATA]}) // R2
          2'b00: d.pl = rtpsd_pkg::RTPSD_PL_NONE; // R4
          2'b01: d.pl = rtpsd_pkg::RTPSD_PL_DATA; // R5
          2'b10: d.pl = rtpsd_pkg::RTPSD_PL_KEY; // R3
          default: begin
            d.pl = rtpsd_pkg::RTPSD_PL_BAD;
            d.invalid = 1'b1; // R6
          end
        endcase
      end
      rtpsd_pkg::ID_DATA_FRAG: begin // R20
        d.kind = rtpsd_pkg::RTPSD_K_FRAG;
        d.has_skip = 1'b1;
        d.inline_qos = d.flags[rtpsd_pkg::F_QOS]; // R11
        d.pl = d.flags[rtpsd_pkg::F_FRAG_KEY] ? rtpsd_pkg::RTPSD_PL_KEY
          : rtpsd_pkg::RTPSD_PL_DATA; // R12
        d.nonstd = d.flags[rtpsd_pkg::F_FRAG_NSTD]; // R13
      end
      rtpsd_pkg::ID_GAP: d.kind = rtpsd_pkg::RTPSD_K_GAP; // R14
      rtpsd_pkg::ID_HEARTBEAT: begin // R21
        d.kind = rtpsd_pkg::RTPSD_K_HB;
        d.final_f = d.flags[rtpsd_pkg::F_FINAL]; // R15
        d.live = d.flags[rtpsd_pkg::F_LIVE]; // R16
      end
      rtpsd_pkg::ID_HB_FRAG: d.kind = rtpsd_pkg::RTPSD_K_HBFRAG; // R17
      default: d.kind = rtpsd_pkg::RTPSD_K_OTHER;
    endcase
  end
endmodule
`default_nettype wire

//--- rtpsd_top.sv
// Submessage header parser and flag decoder with a small register port.
// Assumes an octet stream synchronous to mclk, sof on each submessage id.
// How it works
// R1 - Data flag 0x02 marks inline QoS present.
// R2 - Data flag 0x04 marks serialized data payload.
// R3 - Data flag 0x08 marks serialized key payload.
// R4 - Data with both flags clear has no payload element.
// R5 - Only data flag gives data class, only key flag gives key class.
// R6 - Both data and key set is reported invalid.
// R7 - Data flag 0x10 is the non-standard payload bit, reported with class.
// R8 - Data carries 16 extra flag bits that senders leave at zero.
// R9 - Skip count is 16 bits, counted from the octet after it.
// R10 - Parser skips that many octets before inline QoS or next element.
// R11 - DataFrag flag 0x02 marks inline QoS present.
// R12 - DataFrag flag 0x04 clear means data, set means key.
// R13 - DataFrag flag 0x08 is the non-standard payload bit.
// R14 - Gap uses only the byte order flag.
// R15 - Heartbeat flag 0x02 is final; clear asks the reader to reply.
// R16 - Heartbeat flag 0x04 requests a manual liveliness refresh.
// R17 - HeartbeatFrag uses only the byte order flag.
// R18 - Lowest flag bit selects byte order, set means little-endian.
// R19 - Unused flag bits are ignored when decoding.
// R20 - Identifier 0x15 is Data, 0x16 is DataFrag.
// R21 - Identifiers 0x08, 0x07, 0x13 are Gap, Heartbeat, HeartbeatFrag.
// R22 - Decoded results come with a one-cycle valid strobe after the flags.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rtpsd_top #(
  parameter int unsigned CNT_WIDTH = rtpsd_pkg::CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Octet stream
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic [7:0] in_data,
  // Decoded header
  output logic dec_valid,
  output rtpsd_pkg::rtpsd_kind_e dec_kind,
  output rtpsd_pkg::rtpsd_pl_e dec_pl,
  output logic dec_little_end,
  output logic dec_inline_qos,
  output logic dec_nonstd,
  output logic dec_final,
  output logic dec_live,
  output logic dec_invalid,
  output logic extra_nz,
  output logic qos_start,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef enum logic [3:0] {
    S_IDLE, S_FLAGS, S_LEN0, S_LEN1, S_XF0, S_XF1, S_OQ0, S_OQ1, S_SKIP, S_REST
  } rtpsd_st_e;

  rtpsd_st_e state_reg;
  logic [7:0] id_reg;
  logic [7:0] raw_flags_reg;
  logic [7:0] oq_lo_reg;
  logic [15:0] skip_reg;
  logic le_reg;
  logic skip_kind_reg;
  logic [31:0] ctrl_reg;
  logic [CNT_WIDTH-1:0] invalid_cnt_reg;
  logic [CNT_WIDTH-1:0] dec_cnt_reg;
  logic take;
  logic clr_hit;
  logic [15:0] oq_next;
  rtpsd_dec_if dif ();

  rtpsd_flag_dec u_dec (
    .d(dif.dec)
  );

  assign take = in_valid && ctrl_reg[rtpsd_pkg::CTRL_EN];
  // Software clear of both counters
  assign clr_hit = reg_wr && reg_addr == rtpsd_pkg::OFS_CTRL && reg_wdata[rtpsd_pkg::CTRL_CLR];
  assign dif.sub_id = id_reg;
  assign dif.flags = in_data;

  // Assemble the skip count in the sender's byte order
  function automatic logic [15:0] join16(input logic le, input logic [7:0] first,
      input logic [7:0] second);
    join16 = le ? {second, first} : {first, second};
  endfunction

  assign oq_next = join16(le_reg, oq_lo_reg, in_data); // R9 R18

  function automatic logic [CNT_WIDTH-1:0] bump(input logic [CNT_WIDTH-1:0] v);
    bump = v + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
  endfunction

  // Header walk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
    end else if (take && in_sof) begin
      state_reg <= S_FLAGS;
    end else if (take) begin
      case (state_reg)
        S_FLAGS: state_reg <= S_LEN0;
        S_LEN0: state_reg <= S_LEN1;
        S_LEN1: state_reg <= skip_kind_reg ? S_XF0 : S_REST;
        S_XF0: state_reg <= S_XF1;
        S_XF1: state_reg <= S_OQ0;
        S_OQ0: state_reg <= S_OQ1;
        S_OQ1: state_reg <= (oq_next == 16'h0000) ? S_REST : S_SKIP; // R10
        S_SKIP: state_reg <= (skip_reg == 16'h0001) ? S_REST : S_SKIP; // R10
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Header fields kept during the walk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      id_reg <= 8'h00;
      raw_flags_reg <= 8'h00;
      oq_lo_reg <= 8'h00;
      le_reg <= 1'b0;
      skip_kind_reg <= 1'b0;
    end else if (take) begin
      if (in_sof) begin
        id_reg <= in_data;
      end
      if (state_reg == S_FLAGS && !in_sof) begin
        raw_flags_reg <= in_data;
        le_reg <= dif.little_end; // R18
        skip_kind_reg <= dif.has_skip;
      end
      if (state_reg == S_OQ0 && !in_sof) begin
        oq_lo_reg <= in_data;
      end
    end
  end

  // Skip counter over unknown header elements
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      skip_reg <= 16'h0000;
    end else if (take && !in_sof && state_reg == S_OQ1) begin
      skip_reg <= oq_next; // R10
    end else if (take && !in_sof && state_reg == S_SKIP) begin
      skip_reg <= skip_reg - 16'h0001; // R10
    end
  end

  // Start of inline QoS or the element after it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      qos_start <= 1'b0;
    end else begin
      qos_start <= take && !in_sof && ((state_reg == S_OQ1 && oq_next == 16'h0000)
        || (state_reg == S_SKIP && skip_reg == 16'h0001)); // R10
    end
  end

  // Nonzero extra flags from the sender
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      extra_nz <= 1'b0;
    end else if (take && !in_sof && state_reg == S_XF0) begin
      extra_nz <= (in_data != 8'h00); // R8
    end else if (take && !in_sof && state_reg == S_XF1) begin
      extra_nz <= extra_nz || (in_data != 8'h00); // R8
    end
  end

  // Decoded flag outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dec_valid <= 1'b0;
      dec_kind <= rtpsd_pkg::RTPSD_K_OTHER;
      dec_pl <= rtpsd_pkg::RTPSD_PL_NONE;
      dec_little_end <= 1'b0;
      dec_inline_qos <= 1'b0;
      dec_nonstd <= 1'b0;
      dec_final <= 1'b0;
      dec_live <= 1'b0;
      dec_invalid <= 1'b0;
    end else begin
      dec_valid <= take && !in_sof && state_reg == S_FLAGS; // R22
      if (take && !in_sof && state_reg == S_FLAGS) begin
        dec_kind <= dif.kind;
        dec_pl <= dif.pl;
        dec_little_end <= dif.little_end;
        dec_inline_qos <= dif.inline_qos;
        dec_nonstd <= dif.nonstd;
        dec_final <= dif.final_f;
        dec_live <= dif.live;
        dec_invalid <= dif.invalid;
      end
    end
  end

  // Counters, set wins over software clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      invalid_cnt_reg <= '0;
      dec_cnt_reg <= '0;
    end else begin
      if (dec_valid) begin
        dec_cnt_reg <= bump(dec_cnt_reg);
      end else if (clr_hit) begin
        dec_cnt_reg <= '0;
      end
      if (dec_valid && dec_invalid) begin
        invalid_cnt_reg <= bump(invalid_cnt_reg); // R6
      end else if (clr_hit) begin
        invalid_cnt_reg <= '0;
      end
    end
  end

  // Control register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= rtpsd_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == rtpsd_pkg::OFS_CTRL) begin
      ctrl_reg <= {31'h0000_0000, reg_wdata[rtpsd_pkg::CTRL_EN]};
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        rtpsd_pkg::OFS_CTRL: reg_rdata <= ctrl_reg;
        rtpsd_pkg::OFS_STATUS: reg_rdata <= {12'h000, state_reg, raw_flags_reg, id_reg};
        rtpsd_pkg::OFS_INVALID: reg_rdata <= 32'(invalid_cnt_reg);
        rtpsd_pkg::OFS_DECODED: reg_rdata <= 32'(dec_cnt_reg);
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_DEC_PULSE: assert property ( // R22
    take && !in_sof && state_reg == S_FLAGS |=> dec_valid ##1 !dec_valid)
    else $error("Decode strobe not one cycle after flags");
  AST_DATA_QOS: assert property ( // R1
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_DATA |-> dec_inline_qos == raw_flags_reg[1])
    else $error("Data inline QoS flag wrong");
  AST_DATA_CLASS: assert property ( // R5
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_DATA |->
      dec_pl == (raw_flags_reg[rtpsd_pkg::F_KEY] ? (raw_flags_reg[rtpsd_pkg::F_DATA]
      ? rtpsd_pkg::RTPSD_PL_BAD : rtpsd_pkg::RTPSD_PL_KEY)
      : (raw_flags_reg[rtpsd_pkg::F_DATA]
      ? rtpsd_pkg::RTPSD_PL_DATA : rtpsd_pkg::RTPSD_PL_NONE)))
    else $error("Data payload class wrong");
  AST_DATA_BAD: assert property ( // R6
    dec_valid |-> dec_invalid == (dec_kind == rtpsd_pkg::RTPSD_K_DATA
      && raw_flags_reg[3:2] == 2'b11))
    else $error("Invalid combination report wrong");
  AST_NSTD: assert property ( // R7
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_DATA |-> dec_nonstd == raw_flags_reg[4])
    else $error("Data non-standard flag wrong");
  AST_FRAG: assert property ( // R13
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_FRAG |-> dec_nonstd == raw_flags_reg[3]
      && (dec_pl == rtpsd_pkg::RTPSD_PL_KEY) == raw_flags_reg[2])
    else $error("DataFrag flags wrong");
  AST_HB: assert property ( // R16
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_HB |-> dec_final == raw_flags_reg[1]
      && dec_live == raw_flags_reg[2])
    else $error("Heartbeat flags wrong");
  AST_ONLY_E: assert property ( // R17
    dec_valid && (dec_kind == rtpsd_pkg::RTPSD_K_HBFRAG || dec_kind == rtpsd_pkg::RTPSD_K_GAP)
      |-> !dec_final && !dec_live && !dec_nonstd && !dec_inline_qos)
    else $error("Flags decoded where only byte order is meaningful");
  AST_ENDIAN: assert property ( // R18
    dec_valid |-> dec_little_end == raw_flags_reg[0])
    else $error("Byte order flag wrong");
  AST_SKIP0: assert property ( // R10
    take && !in_sof && state_reg == S_OQ1 && oq_next == 16'h0000 |=> qos_start)
    else $error("Zero skip did not start QoS at once");
  AST_FRAG_QOS: assert property ( // R11
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_FRAG |->
      dec_inline_qos == raw_flags_reg[rtpsd_pkg::F_QOS])
    else $error("DataFrag inline QoS flag wrong");
  AST_FRAG_CLASS: assert property ( // R12
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_FRAG |->
      dec_pl == (raw_flags_reg[rtpsd_pkg::F_FRAG_KEY] ? rtpsd_pkg::RTPSD_PL_KEY
      : rtpsd_pkg::RTPSD_PL_DATA))
    else $error("DataFrag payload class wrong");
  AST_GAP: assert property ( // R14
    dec_valid && dec_kind == rtpsd_pkg::RTPSD_K_GAP |->
      dec_pl == rtpsd_pkg::RTPSD_PL_NONE && !dec_invalid && !dec_final && !dec_live)
    else $error("Gap decoded with more than byte order");
  AST_KIND_DATA: assert property ( // R20
    dec_valid |-> (dec_kind == rtpsd_pkg::RTPSD_K_DATA) == (id_reg == rtpsd_pkg::ID_DATA)
      && (dec_kind == rtpsd_pkg::RTPSD_K_FRAG) == (id_reg == rtpsd_pkg::ID_DATA_FRAG))
    else $error("Data kind does not follow identifier");
  AST_KIND_OTHER: assert property ( // R21
    dec_valid |-> (dec_kind == rtpsd_pkg::RTPSD_K_GAP) == (id_reg == rtpsd_pkg::ID_GAP)
      && (dec_kind == rtpsd_pkg::RTPSD_K_HB) == (id_reg == rtpsd_pkg::ID_HEARTBEAT)
      && (dec_kind == rtpsd_pkg::RTPSD_K_HBFRAG) == (id_reg == rtpsd_pkg::ID_HB_FRAG))
    else $error("Control kind does not follow identifier");
endmodule
`default_nettype wire

//--- rtpsd_peer.sv
// Remote participant model that sends submessage header octets.
// Assumes the receiver takes one octet at each mclk edge with valid high.
`timescale 1ns/10ps
`default_nettype none
module rtpsd_peer (
  // Clock
  input wire logic mclk,
  // Octet stream
  output logic tx_valid,
  output logic tx_sof,
  output logic [7:0] tx_data
);
  initial begin
    tx_valid = 1'b0;
    tx_sof = 1'b0;
    tx_data = 8'hA5;
  end

  // One octet, optionally after an idle cycle with scrambled data
  task automatic put(input logic [7:0] b, input logic first, input logic slow);
    if (slow) begin
      @(posedge mclk);
      tx_valid <= 1'b0;
      tx_sof <= 1'b0;
      tx_data <= ~tx_data;
    end
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_sof <= first;
    tx_data <= b;
  endtask

  // Header, then for Data and DataFrag the extra flags, skip count and skipped octets
  task automatic send(input logic [7:0] id, input logic [7:0] flags, input logic [15:0] xf,
    input logic [15:0] oq, input logic slow);
    int i;
    put(id, 1'b1, slow);
    put(flags, 1'b0, slow);
    put(8'h20, 1'b0, slow);
    put(8'h00, 1'b0, slow);
    if (id == rtpsd_pkg::ID_DATA || id == rtpsd_pkg::ID_DATA_FRAG) begin
      put(flags[0] ? xf[7:0] : xf[15:8], 1'b0, slow);
      put(flags[0] ? xf[15:8] : xf[7:0], 1'b0, slow);
      put(flags[0] ? oq[7:0] : oq[15:8], 1'b0, slow);
      put(flags[0] ? oq[15:8] : oq[7:0], 1'b0, slow);
      for (i = 0; i < oq; i++) begin
        put(8'hC3 ^ i[7:0], 1'b0, slow);
      end
    end
    @(posedge mclk);
    tx_valid <= 1'b0;
    tx_sof <= 1'b0;
    tx_data <= ~tx_data;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the submessage flag decoder.
// Assumes the decoder top and the peer model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk, nrst, in_valid, in_sof, reg_wr, reg_rd;
  logic [7:0] in_data, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic dec_valid, dec_little_end, dec_inline_qos, dec_nonstd, dec_final, dec_live;
  logic dec_invalid, extra_nz, qos_start;
  rtpsd_pkg::rtpsd_kind_e dec_kind, e_kind;
  rtpsd_pkg::rtpsd_pl_e dec_pl, e_pl;
  logic e_le, e_q, e_n, e_f, e_l, e_inv, e_df;
  int mismatches, check_count, n_valid, cycles, i;
  logic [7:0] c_id [0:14] = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h15, 8'h15, 8'h16, 8'h16,
    8'h16, 8'h08, 8'h07, 8'h07, 8'h07, 8'h13, 8'h06};
  logic [7:0] c_flg [0:14] = '{8'h00, 8'h05, 8'h08, 8'h0C, 8'h12, 8'hE4, 8'h06, 8'h09,
    8'hF0, 8'hFF, 8'h02, 8'h05, 8'hF8, 8'hFF, 8'h00};

  rtpsd_top dut (.mclk(mclk), .nrst(nrst), .in_valid(in_valid), .in_sof(in_sof),
    .in_data(in_data), .dec_valid(dec_valid), .dec_kind(dec_kind), .dec_pl(dec_pl),
    .dec_little_end(dec_little_end), .dec_inline_qos(dec_inline_qos),
    .dec_nonstd(dec_nonstd), .dec_final(dec_final), .dec_live(dec_live),
    .dec_invalid(dec_invalid), .extra_nz(extra_nz), .qos_start(qos_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  rtpsd_peer peer (.mclk(mclk), .tx_valid(in_valid), .tx_sof(in_sof), .tx_data(in_data));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Strobe counter and hang limit
  always @(posedge mclk) begin
    if (dec_valid === 1'b1) begin
      n_valid++;
    end
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Expected decode of one header
  task automatic expect_of(input logic [7:0] id, input logic [7:0] f);
    e_kind = rtpsd_pkg::RTPSD_K_OTHER;
    e_pl = rtpsd_pkg::RTPSD_PL_NONE;
    {e_q, e_n, e_f, e_l, e_inv, e_df} = 6'h00;
    e_le = f[0];
    case (id)
      8'h15: begin
        e_kind = rtpsd_pkg::RTPSD_K_DATA;
        {e_q, e_n, e_inv, e_df} = {f[1], f[4], f[2] & f[3], 1'b1};
        e_pl = rtpsd_pkg::rtpsd_pl_e'({f[3], f[2]});
      end
      8'h16: begin
        e_kind = rtpsd_pkg::RTPSD_K_FRAG;
        {e_q, e_n, e_df} = {f[1], f[3], 1'b1};
        e_pl = f[2] ? rtpsd_pkg::RTPSD_PL_KEY : rtpsd_pkg::RTPSD_PL_DATA;
      end
      8'h08: e_kind = rtpsd_pkg::RTPSD_K_GAP;
      8'h07: begin
        e_kind = rtpsd_pkg::RTPSD_K_HB;
        {e_l, e_f} = f[2:1];
      end
      8'h13: e_kind = rtpsd_pkg::RTPSD_K_HBFRAG;
      default: e_kind = rtpsd_pkg::RTPSD_K_OTHER;
    endcase
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {mismatches, check_count, n_valid, cycles} = '0;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    reg_read(rtpsd_pkg::OFS_CTRL, rd);
    chk(rd, rtpsd_pkg::CTRL_RESET);
    reg_write(8'h20, 32'hFFFF_FFFF);
    reg_read(8'h20, rd);
    chk(rd, 32'h0000_0000);
    reg_read(rtpsd_pkg::OFS_CTRL, rd);
    chk(rd, rtpsd_pkg::CTRL_RESET);
    $display("Test registers done");
    reg_write(rtpsd_pkg::OFS_CTRL, 32'h0000_0003);
    for (i = 0; i < 15; i++) begin
      expect_of(c_id[i], c_flg[i]);
      n_valid = 0;
      peer.send(c_id[i], c_flg[i], (i == 4) ? 16'h8001 : 16'h0000, 16'(i % 4), i[0]);
      #1;
      chk(n_valid, 1);
      chk(dec_kind, e_kind);
      chk(dec_pl, e_pl);
      chk(dec_little_end, e_le);
      chk(dec_inline_qos, e_q);
      chk(dec_nonstd, e_n);
      chk({dec_final, dec_live}, {e_f, e_l});
      chk(dec_invalid, e_inv);
      if (e_df) begin
        chk(qos_start, 1'b1);
        chk(extra_nz, i == 4);
      end
    end
    $display("Test decode table done");
    reg_read(rtpsd_pkg::OFS_DECODED, rd);
    chk(rd, 32'd15);
    reg_read(rtpsd_pkg::OFS_INVALID, rd);
    chk(rd, 32'd1);
    reg_read(rtpsd_pkg::OFS_STATUS, rd);
    chk(rd & 32'hFFF0_FFFF, 32'h0000_0006);
    reg_write(rtpsd_pkg::OFS_CTRL, 32'h0000_0000);
    n_valid = 0;
    peer.send(8'h15, 8'h0C, 16'h0000, 16'h0001, 1'b0);
    #1;
    chk(n_valid, 0);
    reg_write(rtpsd_pkg::OFS_CTRL, 32'h0000_0001);
    reg_read(rtpsd_pkg::OFS_INVALID, rd);
    chk(rd, 32'd1);
    $display("Test enable done");
    reg_write(rtpsd_pkg::OFS_CTRL, 32'h0000_0003);
    reg_read(rtpsd_pkg::OFS_DECODED, rd);
    chk(rd, 32'd0);
    reg_read(rtpsd_pkg::OFS_CTRL, rd);
    chk(rd, 32'h0000_0001);
    $display("Test counter clear done");
    end_of_test();
  end
endmodule
`default_nettype wire
